// file: rtl/upsrp_pkg.sv
// package: constants for the utmi status and receive port
package upsrp_pkg;

    // system clock and reference clock rates
    localparam int unsigned MCLK_HZ     = 250_000_000;
    localparam int unsigned REF_CLK_HZ  = 60_000_000;
    localparam int unsigned RATE_UNIT   = 1_000_000;
    // phase accumulator: two toggles per reference period
    localparam logic [8:0]  REF_ACC_STEP = 9'((2 * REF_CLK_HZ) / RATE_UNIT);
    localparam logic [8:0]  REF_ACC_MOD  = 9'(MCLK_HZ / RATE_UNIT);

    // register byte offsets
    localparam logic [7:0]  OFS_EVENT_STAT = 8'h00;
    localparam logic [7:0]  OFS_EVENT_MASK = 8'h04;
    localparam logic [7:0]  OFS_LIVE_STAT  = 8'h08;

    // event status bit positions
    localparam int unsigned EV_DETACH   = 0;
    localparam int unsigned EV_RX_FAULT = 1;
    localparam int unsigned EV_OVERRUN  = 2;
    localparam int unsigned EV_SESS_CHG = 3;
    localparam int unsigned EV_W        = 4;

    // live status bit positions
    localparam int unsigned LV_HOLD_FULL = 0;
    localparam int unsigned LV_LINE_LO   = 1;
    localparam int unsigned LV_DETACH    = 3;
    localparam int unsigned LV_VBUS_VLD  = 4;
    localparam int unsigned LV_SESS_VLD  = 5;
    localparam int unsigned LV_SESS_END  = 6;
    localparam int unsigned LV_CABLE_ID  = 7;

    // values after reset
    localparam logic        RST_CABLE_ID = 1'h1;
    localparam logic        RST_SESS_END = 1'h1;
    localparam logic [1:0]  RST_LINE     = 2'h0;
    localparam logic [3:0]  RST_MASK     = 4'h0;

    // line condition codes, bit 0 follows d+ and bit 1 follows d-
    typedef enum logic [1:0] {
        UPSRP_LINE_SE0 = 2'h0,
        UPSRP_LINE_J   = 2'h1,
        UPSRP_LINE_K   = 2'h2,
        UPSRP_LINE_SE1 = 2'h3
    } upsrp_line_t;

endpackage

// file: rtl/upsrp_port.sv
// utmi status, line condition and receive port of the transceiver
// Functional notes
// R1: plug identity low for A, high B
// R2: sample identity only while enable high
// R3: 60MHz reference out, outputs follow it
// R4: line code bit0 d+, bit1 d-
// R5: line passes through in suspend/resume
// R6: detach flag set in high-speed host
// R7: detach flag cleared in low power
// R8: discharge vbus while control high
// R9: session end high below threshold
// R10: eight-bit data bus, bit7 msb
// R11: receive valid only with full holding
// R12: link captures data at next edge
// R13: session valid high above threshold
// R14: bus power valid above threshold
// R15: d+ pull-down follows its select
// R16: d- pull-down follows its select
// R17: receive fault timed like data
// R18: clocks stop during suspend
// R19: bus driven only while presenting bytes
//
// The implementer's own choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module upsrp_port
    import upsrp_pkg::*;
#(
    parameter int unsigned ADDR_W = 8,
    parameter int unsigned DATA_W = 8
) (
    input  wire logic              mclk,
    input  wire logic              rst,
    // link-side control inputs
    input  wire logic              low_power_request_n,
    input  wire logic              plug_identity_sample_enable,
    input  wire logic              bus_power_discharge_ctl,
    input  wire logic              dplus_pulldown_select,
    input  wire logic              dminus_pulldown_select,
    // analog front-end levels
    input  wire logic              id_line_level,
    input  wire logic              dplus_level,
    input  wire logic              dminus_level,
    input  wire logic              resume_active,
    input  wire logic              host_hs_mode,
    input  wire logic              downstream_gone,
    input  wire logic              vbus_above_sess_end,
    input  wire logic              vbus_above_sess_vld,
    input  wire logic              vbus_above_vbus_vld,
    // receiver byte stream
    input  wire logic [DATA_W-1:0] rx_byte,
    input  wire logic              rx_byte_stb,
    input  wire logic              rx_fault_stb,
    // shared data bus, three signals
    input  wire logic [DATA_W-1:0] data_in,
    output logic [DATA_W-1:0]      data_out,
    output logic                   data_oe,
    // link-side outputs
    output logic                   phy_reference_clock_out,
    output logic                   cable_plug_identity,
    output logic [1:0]             bus_line_condition,
    output logic                   downstream_detach_flag,
    output logic                   session_end_status,
    output logic                   session_valid_status,
    output logic                   bus_power_valid_status,
    output logic                   receive_byte_valid,
    output logic                   receive_fault_flag,
    // analog controls
    output logic                   id_sampler_power_en,
    output logic                   vbus_discharge_en,
    output logic                   dplus_pulldown_en,
    output logic                   dminus_pulldown_en,
    // register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    output logic                   irq
);

    // whole module state
    typedef struct packed {
        logic [1:0]        line_s1;   // synchroniser first stage
        logic [1:0]        line_s2;   // synchroniser second stage
        logic [1:0]        line;      // reported line condition
        logic              cab_id;    // reported plug identity
        logic              id_smp;    // identity sampler powered
        logic              detach;    // downstream detach flag
        logic              sess_end;  // session end status
        logic              sess_vld;  // session valid status
        logic              vbus_vld;  // bus power valid status
        logic              dis_en;    // vbus discharge switch
        logic              dp_pd;     // d+ pull-down switch
        logic              dm_pd;     // d- pull-down switch
        logic [DATA_W-1:0] hold;      // receive holding register
        logic              hold_full; // holding register loaded
        logic              err_pend;  // fault waiting for next edge
        logic [DATA_W-1:0] dout;      // data bus output
        logic              doe;       // data bus drive enable
        logic              rxv;       // receive valid
        logic              rxerr;     // receive fault
        logic [EV_W-1:0]   stat;      // sticky event status
        logic [EV_W-1:0]   mask;      // event mask
        logic              irq;       // interrupt level
        logic [31:0]       rdata;     // read data
    } upsrp_state_t;

    // constant reset image
    localparam upsrp_state_t ST_RST = '{
        cab_id:   RST_CABLE_ID,
        sess_end: RST_SESS_END,
        line:     RST_LINE,
        mask:     RST_MASK,
        default:  '0
    };

    upsrp_state_t st_ff;
    upsrp_state_t nxt_st;
    logic         ref_clk;   // reference clock level
    logic         ref_rise;  // pulse at each reference rising edge
    logic         susp;      // suspended or resuming

    // address match shared by read and write decode
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [7:0] ofs);
        hit = (a == ADDR_W'(ofs));
    endfunction

    // reference clock, stopped while suspended
    upsrp_ref_clk_gen u_ref_gen (
        .mclk     (mclk),
        .rst      (rst),
        .run      (low_power_request_n),  // R18
        .ref_clk  (ref_clk),
        .ref_rise (ref_rise)
    );

    assign susp = !low_power_request_n || resume_active;

    // next state
    always_comb begin
        logic [EV_W-1:0] ev;  // events seen this cycle
        ev     = '0;
        nxt_st = st_ff;

        // analog switches track their selects
        nxt_st.dis_en = bus_power_discharge_ctl;  // R8
        nxt_st.dp_pd  = dplus_pulldown_select;    // R15
        nxt_st.dm_pd  = dminus_pulldown_select;   // R16
        nxt_st.id_smp = plug_identity_sample_enable;  // R2

        // line synchroniser, bit 0 is d+
        nxt_st.line_s1 = {dminus_level, dplus_level};  // R4
        nxt_st.line_s2 = st_ff.line_s1;

        // receiver loads holding register
        if (rx_byte_stb) begin
            nxt_st.hold      = rx_byte;
            nxt_st.hold_full = 1'b1;
            ev[EV_OVERRUN]   = st_ff.hold_full && !ref_rise;
        end
        if (rx_fault_stb) begin
            nxt_st.err_pend = 1'b1;
        end

        // line condition path
        if (susp) begin
            // pass straight through while suspended or resuming
            nxt_st.line = {dminus_level, dplus_level};  // R5
        end else if (ref_rise) begin
            nxt_st.line = st_ff.line_s2;  // R5
        end

        // detach flag forced low in low power
        if (!low_power_request_n) begin
            nxt_st.detach = 1'b0;  // R7
        end else if (ref_rise) begin
            nxt_st.detach = host_hs_mode && downstream_gone;  // R6
            ev[EV_DETACH] = host_hs_mode && downstream_gone && !st_ff.detach;
        end

        // outside suspend and resume, link outputs change on reference edges
        if (ref_rise) begin  // R3
            if (plug_identity_sample_enable) begin
                nxt_st.cab_id = id_line_level;  // R1 R2
            end
            nxt_st.sess_end = !vbus_above_sess_end;  // R9
            nxt_st.sess_vld = vbus_above_sess_vld;   // R13
            nxt_st.vbus_vld = vbus_above_vbus_vld;   // R14
            ev[EV_SESS_CHG] = vbus_above_sess_vld != st_ff.sess_vld;
            // unload holding register onto the bus
            if (st_ff.hold_full) begin
                nxt_st.dout = st_ff.hold;      // R10
                nxt_st.doe  = 1'b1;            // R19
                nxt_st.rxv  = 1'b1;            // R11
                nxt_st.hold_full = rx_byte_stb;  // new byte wins
            end else begin
                nxt_st.doe = 1'b0;  // R19
                nxt_st.rxv = 1'b0;  // R11
            end
            // fault travels with its byte; a fault strobed on this edge
            // waits, like a byte loaded now, for the next reference edge
            nxt_st.rxerr    = st_ff.err_pend;  // R17
            nxt_st.err_pend = rx_fault_stb;
            ev[EV_RX_FAULT] = st_ff.err_pend;
        end

        // suspend releases the bus
        if (!low_power_request_n) begin
            nxt_st.doe = 1'b0;  // R19
            nxt_st.rxv = 1'b0;
        end

        // register writes
        if (reg_wr) begin
            if (hit(reg_addr, OFS_EVENT_STAT)) begin
                nxt_st.stat = st_ff.stat & ~reg_wdata[EV_W-1:0];
            end else if (hit(reg_addr, OFS_EVENT_MASK)) begin
                nxt_st.mask = reg_wdata[EV_W-1:0];
            end
        end
        // new events win over a clear
        nxt_st.stat = nxt_st.stat | ev;
        nxt_st.irq  = |(nxt_st.stat & nxt_st.mask);

        // register reads, data in the next cycle only
        nxt_st.rdata = '0;
        if (reg_rd) begin
            if (hit(reg_addr, OFS_EVENT_STAT)) begin
                nxt_st.rdata = 32'(st_ff.stat);
            end else if (hit(reg_addr, OFS_EVENT_MASK)) begin
                nxt_st.rdata = 32'(st_ff.mask);
            end else if (hit(reg_addr, OFS_LIVE_STAT)) begin
                nxt_st.rdata[LV_HOLD_FULL]           = st_ff.hold_full;
                nxt_st.rdata[LV_LINE_LO +: 2]        = st_ff.line;
                nxt_st.rdata[LV_DETACH]              = st_ff.detach;
                nxt_st.rdata[LV_VBUS_VLD]            = st_ff.vbus_vld;
                nxt_st.rdata[LV_SESS_VLD]            = st_ff.sess_vld;
                nxt_st.rdata[LV_SESS_END]            = st_ff.sess_end;
                nxt_st.rdata[LV_CABLE_ID]            = st_ff.cab_id;
            end
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= ST_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from flops
    assign phy_reference_clock_out = ref_clk;
    assign cable_plug_identity     = st_ff.cab_id;
    assign bus_line_condition      = st_ff.line;
    assign downstream_detach_flag  = st_ff.detach;
    assign session_end_status      = st_ff.sess_end;
    assign session_valid_status    = st_ff.sess_vld;
    assign bus_power_valid_status  = st_ff.vbus_vld;
    assign receive_byte_valid      = st_ff.rxv;
    assign receive_fault_flag      = st_ff.rxerr;
    assign data_out                = st_ff.dout;
    assign data_oe                 = st_ff.doe;
    assign id_sampler_power_en     = st_ff.id_smp;
    assign vbus_discharge_en       = st_ff.dis_en;
    assign dplus_pulldown_en       = st_ff.dp_pd;
    assign dminus_pulldown_en      = st_ff.dm_pd;
    assign reg_rdata               = st_ff.rdata;
    assign irq                     = st_ff.irq;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    a_valid_drives_bus: assert property (  // R11
        receive_byte_valid |-> data_oe)
        else $error("receive valid without bus drive");

    a_bus_only_rx: assert property (  // R19
        data_oe |-> receive_byte_valid)
        else $error("bus driven without a received byte");

    a_detach_cleared: assert property (  // R7
        !low_power_request_n |=> !downstream_detach_flag)
        else $error("detach flag not cleared in low power");

    a_ref_clk_stops: assert property (  // R18
        !low_power_request_n ##1 !low_power_request_n |=> !phy_reference_clock_out)
        else $error("reference clock runs in suspend");

    a_id_hold: assert property (  // R2
        !plug_identity_sample_enable |=> $stable(cable_plug_identity))
        else $error("identity changed while sampling off");

    a_line_susp: assert property (  // R5
        !low_power_request_n |=> bus_line_condition == $past({dminus_level, dplus_level}))
        else $error("line condition not passed in suspend");

    a_rx_on_edge: assert property (  // R3
        $changed(receive_byte_valid) && $past(low_power_request_n) |-> $past(ref_rise))
        else $error("receive valid changed off reference edge");

    a_sess_end: assert property (  // R9
        ref_rise |=> session_end_status == !$past(vbus_above_sess_end))
        else $error("session end wrong polarity");

    a_sess_vld: assert property (  // R13
        ref_rise |=> session_valid_status == $past(vbus_above_sess_vld))
        else $error("session valid not updated");

    a_pd_follow: assert property (  // R15
        ##1 dplus_pulldown_en == $past(dplus_pulldown_select))
        else $error("d+ pull-down does not follow select");

    a_fault_timing: assert property (  // R17
        ref_rise && st_ff.err_pend |=> receive_fault_flag)
        else $error("receive fault not shown at edge");

    a_detach_hs: assert property (  // R6
        ref_rise && low_power_request_n && host_hs_mode && downstream_gone |=> downstream_detach_flag)
        else $error("detach not flagged in high-speed host");

    a_vbus_valid: assert property (  // R14
        ref_rise |=> bus_power_valid_status == $past(vbus_above_vbus_vld))
        else $error("bus power valid not updated");

    a_dm_pd_follow: assert property (  // R16
        ##1 dminus_pulldown_en == $past(dminus_pulldown_select))
        else $error("d- pull-down does not follow select");

    a_discharge_follow: assert property (  // R8
        ##1 vbus_discharge_en == $past(bus_power_discharge_ctl))
        else $error("discharge switch does not follow control");

    a_id_sample: assert property (  // R1
        ref_rise && plug_identity_sample_enable |=> cable_plug_identity == $past(id_line_level))
        else $error("plug identity not sampled");

    c_byte_out: cover property (ref_rise && st_ff.hold_full ##1 receive_byte_valid);
    c_fault: cover property (receive_fault_flag && receive_byte_valid);
    c_irq: cover property (!irq ##1 irq);
    c_suspend: cover property (low_power_request_n ##1 !low_power_request_n);

endmodule
`default_nettype wire

// file: rtl/upsrp_ref_clk_gen.sv
// reference clock generator: fractional divider from mclk
`timescale 1ns/1ps
`default_nettype none
module upsrp_ref_clk_gen
    import upsrp_pkg::*;
(
    input  wire logic mclk,
    input  wire logic rst,
    input  wire logic run,
    output logic      ref_clk,
    output logic      ref_rise
);

    // divider state
    typedef struct packed {
        logic [8:0] acc;   // phase accumulator
        logic       clk;   // reference clock level
        logic       rise;  // one-cycle pulse at rising edge
    } upsrp_gen_t;

    upsrp_gen_t st_ff;
    upsrp_gen_t nxt_st;

    // next state: add step, toggle on wrap, park low when stopped
    always_comb begin
        nxt_st      = st_ff;
        nxt_st.rise = 1'b0;
        if (!run) begin
            nxt_st.acc = '0;
            nxt_st.clk = 1'b0;
        end else if (st_ff.acc + REF_ACC_STEP >= REF_ACC_MOD) begin
            nxt_st.acc  = st_ff.acc + REF_ACC_STEP - REF_ACC_MOD;
            nxt_st.clk  = ~st_ff.clk;
            nxt_st.rise = ~st_ff.clk;
        end else begin
            nxt_st.acc = st_ff.acc + REF_ACC_STEP;
        end
    end

    // state register
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            st_ff <= '0;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign ref_clk  = st_ff.clk;
    assign ref_rise = st_ff.rise;

endmodule
`default_nettype wire

// file: verification/testbench.sv
// self-checking bench for the utmi status and receive port
`timescale 1ns/1ps
`default_nettype none
module testbench
    import upsrp_pkg::*;
;
    logic        mclk, rst, lp_n, id_en, dis_ctl, dp_sel, dm_sel, id_lvl, dp_lvl, dm_lvl;
    logic        resume, hs_host, gone, a_se, a_sv, a_vv, rx_stb, flt_stb, wr, rd, rd_q;
    logic [7:0]  rx_byte, bus, data_out, addr, b;
    logic [31:0] wdata, rdata;
    logic        data_oe, ref_clk, cable_id, detach, sess_end, sess_vld, vbus_vld;
    logic        rx_valid, rx_fault, id_pwr, dis_en, dp_en, dm_en, irq, cap_stb, prev;
    logic [1:0]  line;
    logic [8:0]  cap_word;
    logic [8:0]  rxq[$];   // expected {fault, byte} captures
    logic [63:0] rq[$];    // expected {mask, data} register reads
    int          error_cnt, compares, cnt;

    upsrp_port upsrp_port_inst (
        .mclk(mclk), .rst(rst), .low_power_request_n(lp_n), .plug_identity_sample_enable(id_en),
        .bus_power_discharge_ctl(dis_ctl), .dplus_pulldown_select(dp_sel),
        .dminus_pulldown_select(dm_sel), .id_line_level(id_lvl), .dplus_level(dp_lvl),
        .dminus_level(dm_lvl), .resume_active(resume), .host_hs_mode(hs_host),
        .downstream_gone(gone), .vbus_above_sess_end(a_se), .vbus_above_sess_vld(a_sv),
        .vbus_above_vbus_vld(a_vv), .rx_byte(rx_byte), .rx_byte_stb(rx_stb),
        .rx_fault_stb(flt_stb), .data_in(bus), .data_out(data_out), .data_oe(data_oe),
        .phy_reference_clock_out(ref_clk), .cable_plug_identity(cable_id),
        .bus_line_condition(line), .downstream_detach_flag(detach), .session_end_status(sess_end),
        .session_valid_status(sess_vld), .bus_power_valid_status(vbus_vld),
        .receive_byte_valid(rx_valid), .receive_fault_flag(rx_fault), .id_sampler_power_en(id_pwr),
        .vbus_discharge_en(dis_en), .dplus_pulldown_en(dp_en), .dminus_pulldown_en(dm_en),
        .reg_addr(addr), .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .irq(irq)
    );

    upsrp_link_model upsrp_link_model_inst (
        .mclk(mclk), .rst(rst), .ref_clk(ref_clk), .rx_valid(rx_valid), .rx_fault(rx_fault),
        .data_out(data_out), .data_oe(data_oe), .bus(bus), .cap_stb(cap_stb), .cap_word(cap_word)
    );

    // 250 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #2 mclk = ~mclk;
    end

    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
    endtask

    // register write, one strobe cycle
    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
        @(posedge mclk);
    endtask

    // register read, expectation noted for the watcher
    task automatic reg_read(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] msk);
        addr <= a;
        rd   <= 1'b1;
        rq.push_back({msk, exp});
        @(posedge mclk);
        rd <= 1'b0;
        @(posedge mclk);
    endtask

    // receiver byte strobe, expectation noted for the watcher
    task automatic send_byte(input logic [7:0] v, input logic f);
        rx_byte <= v;
        rx_stb  <= 1'b1;
        flt_stb <= f;
        rxq.push_back({f, v});
        @(posedge mclk);
        rx_stb  <= 1'b0;
        flt_stb <= 1'b0;
    endtask

    // watcher: read data in the cycle after a read, captured bytes from the link
    always @(posedge mclk) begin
        logic [63:0] e;
        logic [8:0]  x;
        if (rd_q) begin
            e = rq.pop_front();
            chk(rdata & e[63:32], e[31:0], "register read");
        end
        rd_q <= rd;
        if (cap_stb) begin
            x = (rxq.size() > 0) ? rxq.pop_front() : 9'h1FF;
            chk({23'h0, cap_word}, {23'h0, x}, "captured byte");
        end
    end

    task automatic test_done;
        $display("compares %0d error_cnt %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // watchdog, the whole run needs well under 20 us
    initial begin
        #100us;
        error_cnt++;
        test_done();
    end

    // main sequence
    initial begin
        {lp_n, id_en, id_lvl} = 3'h7;
        {dis_ctl, dp_sel, dm_sel, dp_lvl, dm_lvl, resume, hs_host, gone} = 8'h00;
        {a_se, a_sv, a_vv, rx_stb, flt_stb, wr, rd} = 7'h00;
        {rx_byte, addr, wdata} = '0;
        error_cnt = 0;
        compares  = 0;
        rst = 1'b1;
        tick(2);
        rst <= 1'b0;
        void'($urandom(67));
        tick(2);
        chk(cable_id, 1'b1, "identity after reset");
        chk(sess_end, 1'b1, "session end after reset");
        // reference clock rate over one microsecond
        cnt  = 0;
        prev = ref_clk;
        repeat (250) begin
            @(posedge mclk);
            cnt += (ref_clk && !prev) ? 1 : 0;
            prev = ref_clk;
        end
        chk(32'(cnt >= 59 && cnt <= 61), 1, "reference rises per us");
        // levels and selects, every line code twice
        for (int i = 0; i < 8; i++) begin
            b = 8'($urandom());
            {a_se, a_sv, a_vv, id_lvl} <= b[3:0];
            {dis_ctl, dp_sel, dm_sel} <= b[6:4];
            {dm_lvl, dp_lvl} <= 2'(i);
            tick(10);
            chk(sess_end, !b[3], "session end");
            chk(sess_vld, b[2], "session valid");
            chk(vbus_vld, b[1], "bus power valid");
            chk(cable_id, b[0], "plug identity");
            chk(32'(line), 32'(i[1:0]), "line code");
            chk({id_pwr, dis_en, dp_en, dm_en}, {1'b1, b[6:4]}, "analog controls");
            reg_read(OFS_LIVE_STAT, {24'h0, b[0], !b[3], b[2], b[1], 1'b0, 2'(i), 1'b0}, 32'hFE);
        end
        // identity sampler off: output holds
        id_en  <= 1'b0;
        tick(10);
        b[0] = cable_id;
        id_lvl <= ~id_lvl;
        tick(10);
        chk({id_pwr, cable_id}, {1'b0, b[0]}, "identity holds");
        // received bytes, the last one with a fault
        for (int i = 0; i < 6; i++) begin
            send_byte(8'($urandom()), i == 5);
            tick(12);
        end
        // overrun: two bytes inside one reference period
        prev = ref_clk;
        do begin
            @(posedge mclk);
            cnt  = (ref_clk && !prev) ? 1 : 0;
            prev = ref_clk;
        end while (cnt == 0);
        rx_byte <= 8'h5A;
        rx_stb  <= 1'b1;
        @(posedge mclk);
        send_byte(8'hA5, 1'b0);
        tick(12);
        reg_read(OFS_EVENT_STAT, 32'h6, 32'h6);
        reg_read(8'h0C, 32'h0, 32'hFFFFFFFF);
        chk(irq, 1'b0, "irq masked");
        reg_write(OFS_EVENT_MASK, 32'h4);
        tick(1);
        chk(irq, 1'b1, "irq unmasked");
        reg_write(OFS_EVENT_STAT, 32'h4);
        tick(1);
        chk(irq, 1'b0, "irq cleared");
        // host disconnect, then suspend
        hs_host <= 1'b1;
        gone    <= 1'b1;
        tick(10);
        chk(detach, 1'b1, "detach flag");
        reg_read(OFS_EVENT_STAT, 32'h1, 32'h1);
        lp_n <= 1'b0;
        tick(3);
        chk(detach, 1'b0, "detach cleared in suspend");
        cnt = 0;
        repeat (20) begin
            @(posedge mclk);
            cnt += (ref_clk !== 1'b0) ? 1 : 0;
        end
        chk(32'(cnt), 0, "reference stopped");
        {dm_lvl, dp_lvl} <= 2'h2;
        tick(2);
        chk(32'(line), 32'h2, "line passes in suspend");
        resume <= 1'b1;
        {dm_lvl, dp_lvl} <= 2'h1;
        tick(2);
        chk(32'(line), 32'h1, "line passes in resume");
        resume  <= 1'b0;
        lp_n    <= 1'b1;
        hs_host <= 1'b0;
        tick(20);
        chk(32'(rxq.size() + rq.size()), 0, "pending results");
        test_done();
    end
endmodule
`default_nettype wire

// file: verification/upsrp_link_model.sv
// link controller model: watches the shared bus and captures received bytes
`timescale 1ns/1ps
`default_nettype none
module upsrp_link_model
    import upsrp_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire logic       ref_clk,
    input  wire logic       rx_valid,
    input  wire logic       rx_fault,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    output logic [7:0]      bus,
    output logic            cap_stb,
    output logic [8:0]      cap_word
);
    logic       ref_q;  // reference level one mclk back
    logic [9:0] pre_q;  // valid, fault and bus level before the last edge

    // link stays off the bus while receiving; released bus is pulled low
    assign bus = data_oe ? data_out : 8'h00;

    // capture on the reference rising edge using the pre-edge values
    always_ff @(posedge mclk or posedge rst) begin
        if (rst) begin
            ref_q    <= 1'b0;
            pre_q    <= '0;
            cap_stb  <= 1'b0;
            cap_word <= '0;
        end else begin
            ref_q    <= ref_clk;
            pre_q    <= {rx_valid, rx_fault, bus};
            cap_stb  <= ref_clk && !ref_q && (pre_q[9] || pre_q[8]);
            cap_word <= pre_q[8:0];
        end
    end
endmodule
`default_nettype wire
